// >>> fsu_flash_guard.sv
// flash block protection, vector redirection and security gate
`timescale 1ns/1ps
module fsu_flash_guard
   import fsu_pkg::*;
#(
   parameter int KEY_BYTES = FSU_KEY_BYTES
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // wishbone classic slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic i_wb_bdm,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // nonvolatile bytes and stored key
   input wire logic [7:0] i_nv_prot,
   input wire logic [7:0] i_nv_opt,
   input wire logic [KEY_BYTES*8-1:0] i_backdoor_key,
   input wire logic i_background_mode_pin,
   // memory access path
   input wire fsu_mem_req_t i_mem_req,
   input wire logic [7:0] i_mem_rdata,
   output logic [15:0] o_mem_addr,
   output logic o_mem_wr_en,
   output logic o_mem_rd_en,
   output logic [7:0] o_mem_rdata,
   output logic o_key_capture,
   // command launch
   input wire fsu_cmd_t i_cmd,
   output fsu_cmd_res_t o_cmd_res,
   // blank check outcome, one-cycle pulse
   input wire logic i_blank_done,
   input wire logic i_blank_pass,
   input wire logic i_blank_bdm,
   // debug permissions
   output logic o_debug_en_ok,
   output logic o_bgnd_mode_ok,
   output logic o_secure
);
   localparam int IW = $clog2(KEY_BYTES);

   initial begin
      if (KEY_BYTES != FSU_KEY_BYTES)
         $error("fsu_flash_guard: key length must be eight bytes");
   end

   logic [7:0] working_protect_reg_r;
   logic [7:0] working_option_reg_r;
   logic [7:0] flash_config_reg_r;
   logic load_pend_r;
   logic bgnd_req_r;
   logic unlocked_r;
   logic key_bad_r;
   logic ack_r;
   logic [31:0] rdat_r;
   fsu_key_st_t key_st_r;
   fsu_key_st_t key_st_nxt;

   logic [6:0] boundary_select_upper;
   logic [15:0] last_unprot;
   logic prot_on;
   logic partial;
   logic redir_on;
   logic [1:0] security_state_bits;
   logic secure;
   logic backdoor_enable_bit;
   logic key_access_bit;
   logic wb_req;
   logic wb_wr;
   logic key_wr;
   logic key_match;
   logic blocked;
   logic cfg_wr;
   logic key_access_bit_new;

   function automatic logic addr_protected(input logic [15:0] a, input logic on,
                                           input logic [15:0] last);
      addr_protected = on && ((a > last) || (a >= FSU_VEC_LO));
   endfunction

   function automatic logic in_key_range(input logic [15:0] a);
      in_key_range = (a >= FSU_KEY_BASE) && (a < FSU_KEY_BASE + 16'(KEY_BYTES));
   endfunction

   // decode of the working copies
   assign boundary_select_upper = working_protect_reg_r[FSU_BND_LSB +: FSU_BND_W];
   assign last_unprot = {boundary_select_upper, {FSU_PAGE_BITS{1'b1}}};
   assign prot_on = !working_protect_reg_r[FSU_PROT_DIS_BIT];
   assign partial = prot_on && (boundary_select_upper != FSU_BND_NONE)
                    && (boundary_select_upper != FSU_BND_ALL);
   assign redir_on = partial && !working_option_reg_r[FSU_NORED_BIT];
   assign security_state_bits = working_option_reg_r[FSU_SEC_LSB +: 2];
   assign secure = (security_state_bits != FSU_SEC_OPEN) && !unlocked_r;
   assign backdoor_enable_bit = working_option_reg_r[FSU_BACKDOOR_ENABLE_BIT_BIT];
   assign key_access_bit = flash_config_reg_r[FSU_KEY_ACCESS_BIT_BIT];

   // wishbone decode
   assign wb_req = i_wb_cyc && i_wb_stb && !ack_r;
   assign wb_wr = wb_req && i_wb_we && i_wb_sel[0];
   assign cfg_wr = wb_wr && (i_wb_adr == FSU_OFS_CFG);
   assign key_access_bit_new = i_wb_dat[FSU_KEY_ACCESS_BIT_BIT];

   // nonvolatile bytes are taken in the first cycle after reset release,
   // so reset itself only ever loads constants
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         load_pend_r <= 1'b1;
      end else begin
         load_pend_r <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         working_protect_reg_r <= FSU_PROT_RST;
      end else if (load_pend_r) begin
         working_protect_reg_r <= i_nv_prot;
      end else if (wb_wr && i_wb_bdm && (i_wb_adr == FSU_OFS_PROT)) begin
         working_protect_reg_r <= i_wb_dat[7:0];
      end
   end

   // option register is read-only to software, changed only by reload
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         working_option_reg_r <= FSU_OPT_RST;
      end else if (load_pend_r) begin
         working_option_reg_r <= i_nv_opt;
      end
   end

   // background mode pin sampled at release of reset
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         bgnd_req_r <= 1'b0;
      end else if (load_pend_r) begin
         bgnd_req_r <= !i_background_mode_pin;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         flash_config_reg_r <= FSU_CFG_RST;
      end else if (cfg_wr) begin
         flash_config_reg_r <= {2'b00, key_access_bit_new, 5'b00000};
      end
   end

   // backdoor key entry sequence
   always_comb begin
      key_st_nxt = key_st_r;
      unique case (key_st_r)
         KS_IDLE: begin
            // only secure firmware with the backdoor enabled may start
            if (cfg_wr && key_access_bit_new && !i_wb_bdm && backdoor_enable_bit && secure) begin
               key_st_nxt = KS_ENTER;
            end
         end
         KS_ENTER: begin
            if (cfg_wr && !key_access_bit_new) begin
               key_st_nxt = i_wb_bdm ? KS_IDLE : KS_CHECK;
            end
         end
         KS_CHECK: begin
            key_st_nxt = KS_IDLE;
         end
         default: begin
            key_st_nxt = KS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         key_st_r <= KS_IDLE;
      end else begin
         key_st_r <= key_st_nxt;
      end
   end

   // key writes must come from secure code, debug writes are not captured
   assign key_wr = i_mem_req.valid && i_mem_req.write && key_access_bit
                   && in_key_range(i_mem_req.addr)
                   && i_mem_req.src_secure && !i_mem_req.from_bdm
                   && (key_st_r == KS_ENTER);

   fsu_key_cmp #(
      .KEY_BYTES(KEY_BYTES)
   ) u_key_cmp (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_clr(key_st_r == KS_IDLE),
      .i_wr(key_wr),
      .i_idx(i_mem_req.addr[IW-1:0]),
      .i_byte(i_mem_req.wdata),
      .i_key(i_backdoor_key),
      .o_match(key_match)
   );

   // unlock is sticky until reset; nothing here can relock
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         unlocked_r <= 1'b0;
      end else if (key_st_r == KS_CHECK && key_match) begin
         unlocked_r <= 1'b1;
      end else if (i_blank_done && i_blank_pass && i_blank_bdm) begin
         unlocked_r <= 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         key_bad_r <= 1'b0;
      end else if (key_st_r == KS_CHECK) begin
         key_bad_r <= !key_match;
      end
   end

   // memory gate
   assign blocked = secure && i_mem_req.tgt_secure
                    && (!i_mem_req.src_secure || i_mem_req.from_bdm);

   always_comb begin
      o_mem_addr = i_mem_req.addr;
      if (i_mem_req.vec_fetch && redir_on && (i_mem_req.addr >= FSU_VEC_LO)
          && (i_mem_req.addr <= FSU_VEC_HI)) begin
         // reset vector lies above the range and is never moved
         o_mem_addr = {last_unprot[15:FSU_PAGE_BITS],
                       i_mem_req.addr[FSU_PAGE_BITS-1:0]};
      end
   end

   assign o_key_capture = key_wr;
   assign o_mem_wr_en = i_mem_req.valid && i_mem_req.write && !blocked
                        && !(key_access_bit && in_key_range(i_mem_req.addr));
   assign o_mem_rd_en = i_mem_req.valid && !i_mem_req.write;

   // read data returns one cycle after the request
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_mem_rdata <= 8'h00;
      end else if (o_mem_rd_en) begin
         o_mem_rdata <= blocked ? 8'h00 : i_mem_rdata;
      end
   end

   // command screening, results registered one cycle after launch
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_cmd_res <= '0;
      end else begin
         o_cmd_res <= '0;
         if (i_cmd.valid) begin
            if (secure && i_cmd.from_bdm && (i_cmd.code != FSU_CMD_BLANK)
                && (i_cmd.code != FSU_CMD_MASS)) begin
               o_cmd_res.access_err <= 1'b1;
            end else if ((i_cmd.code == FSU_CMD_PROG || i_cmd.code == FSU_CMD_BURST
                          || i_cmd.code == FSU_CMD_PAGE)
                         && addr_protected(i_cmd.addr, prot_on, last_unprot)) begin
               o_cmd_res.prot_reject <= 1'b1;
            end else if (i_cmd.code == FSU_CMD_MASS && prot_on) begin
               // mass erase would reach into the protected block
               o_cmd_res.prot_reject <= 1'b1;
            end else begin
               o_cmd_res.accept <= 1'b1;
            end
         end
      end
   end

   assign o_secure = secure;
   assign o_debug_en_ok = !secure;
   assign o_bgnd_mode_ok = !secure || bgnd_req_r;

   // wishbone answer one cycle after the strobe
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= wb_req;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         rdat_r <= 32'h0000_0000;
      end else if (wb_req) begin
         unique case (i_wb_adr)
            FSU_OFS_PROT: rdat_r <= {24'h00_0000, working_protect_reg_r};
            FSU_OFS_OPT: rdat_r <= {24'h00_0000, working_option_reg_r};
            FSU_OFS_CFG: rdat_r <= {24'h00_0000, flash_config_reg_r};
            FSU_OFS_STAT: begin
               rdat_r <= 32'h0000_0000;
               rdat_r[FSU_ST_SECURE] <= secure;
               rdat_r[FSU_ST_UNLOCKED] <= unlocked_r;
               rdat_r[FSU_ST_PROT_ON] <= prot_on;
               rdat_r[FSU_ST_REDIR_ON] <= redir_on;
               rdat_r[FSU_ST_BGND_OK] <= o_bgnd_mode_ok;
               rdat_r[FSU_ST_KEY_BAD] <= key_bad_r;
            end
            default: rdat_r <= 32'h0000_0000;
         endcase
      end
   end

   assign o_wb_ack = ack_r;
   assign o_wb_dat = rdat_r;
endmodule

// >>> fsu_pkg.sv
// shared constants and carrier types for the flash protect and security unit
package fsu_pkg;
   // register bus map, byte addresses on a 32-bit wishbone
   localparam logic [7:0] FSU_OFS_PROT = 8'h00;
   localparam logic [7:0] FSU_OFS_OPT = 8'h04;
   localparam logic [7:0] FSU_OFS_CFG = 8'h08;
   localparam logic [7:0] FSU_OFS_STAT = 8'h0c;
   // nonvolatile locations in the flash register block
   localparam logic [15:0] FSU_NV_PROT_ADDR = 16'hffbd;
   localparam logic [15:0] FSU_NV_OPT_ADDR = 16'hffbf;
   localparam logic [15:0] FSU_KEY_BASE = 16'hffb0;
   // protection byte layout
   localparam int FSU_PROT_DIS_BIT = 0;
   localparam int FSU_BND_LSB = 1;
   localparam int FSU_BND_W = 7;
   localparam int FSU_PAGE_BITS = 9;
   localparam logic [6:0] FSU_BND_NONE = 7'h7f;
   localparam logic [6:0] FSU_BND_ALL = 7'h00;
   // option byte layout
   localparam int FSU_SEC_LSB = 0;
   localparam logic [1:0] FSU_SEC_OPEN = 2'h2;
   localparam int FSU_NORED_BIT = 6;
   localparam int FSU_BACKDOOR_ENABLE_BIT_BIT = 7;
   // config byte layout
   localparam int FSU_KEY_ACCESS_BIT_BIT = 5;
   // status word layout
   localparam int FSU_ST_SECURE = 0;
   localparam int FSU_ST_UNLOCKED = 1;
   localparam int FSU_ST_PROT_ON = 2;
   localparam int FSU_ST_REDIR_ON = 3;
   localparam int FSU_ST_BGND_OK = 4;
   localparam int FSU_ST_KEY_BAD = 5;
   // reset values of working registers, erased flash reads as ones
   localparam logic [7:0] FSU_PROT_RST = 8'hff;
   localparam logic [7:0] FSU_OPT_RST = 8'hff;
   localparam logic [7:0] FSU_CFG_RST = 8'h00;
   // vector space
   localparam logic [15:0] FSU_VEC_LO = 16'hffc0;
   localparam logic [15:0] FSU_VEC_HI = 16'hfffd;
   // flash commands
   localparam logic [7:0] FSU_CMD_BLANK = 8'h05;
   localparam logic [7:0] FSU_CMD_PROG = 8'h20;
   localparam logic [7:0] FSU_CMD_BURST = 8'h25;
   localparam logic [7:0] FSU_CMD_PAGE = 8'h40;
   localparam logic [7:0] FSU_CMD_MASS = 8'h41;
   localparam int FSU_KEY_BYTES = 8;

   // memory access from the cpu or the background controller
   typedef struct packed {
      logic valid;
      logic write;
      logic vec_fetch;
      logic src_secure;
      logic from_bdm;
      logic tgt_secure;
      logic [15:0] addr;
      logic [7:0] wdata;
   } fsu_mem_req_t;

   // flash command presented at launch
   typedef struct packed {
      logic valid;
      logic from_bdm;
      logic [7:0] code;
      logic [15:0] addr;
   } fsu_cmd_t;

   // verdict on a launched command
   typedef struct packed {
      logic accept;
      logic prot_reject;
      logic access_err;
   } fsu_cmd_res_t;

   typedef enum logic [2:0] {
      KS_IDLE = 3'b001,
      KS_ENTER = 3'b010,
      KS_CHECK = 3'b100
   } fsu_key_st_t;
endpackage

// >>> fsu_key_cmp.sv
// backdoor key capture buffer and comparator
`timescale 1ns/1ps
module fsu_key_cmp #(
   parameter int KEY_BYTES = 8
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_clr,
   input wire logic i_wr,
   input wire logic [$clog2(KEY_BYTES)-1:0] i_idx,
   input wire logic [7:0] i_byte,
   input wire logic [KEY_BYTES*8-1:0] i_key,
   output logic o_match
);
   localparam int IW = $clog2(KEY_BYTES);

   initial begin
      if (KEY_BYTES < 2 || (1 << IW) != KEY_BYTES)
         $error("fsu_key_cmp: KEY_BYTES must be a power of two");
   end

   logic [7:0] key_r [KEY_BYTES];
   logic [IW:0] next_r;
   logic order_bad_r;
   logic eq;

   always_ff @(posedge i_ref_clk) begin
      if (i_rst || i_clr) begin
         for (int i = 0; i < KEY_BYTES; i++) begin
            key_r[i] <= 8'h00;
         end
      end else if (i_wr) begin
         key_r[i_idx] <= i_byte;
      end
   end

   // bytes out of ascending order spoil the attempt
   always_ff @(posedge i_ref_clk) begin
      if (i_rst || i_clr) begin
         next_r <= '0;
         order_bad_r <= 1'b0;
      end else if (i_wr) begin
         if ({1'b0, i_idx} != next_r) begin
            order_bad_r <= 1'b1;
         end
         next_r <= next_r + 1'b1;
      end
   end

   always_comb begin
      eq = 1'b1;
      for (int i = 0; i < KEY_BYTES; i++) begin
         if (key_r[i] != i_key[i*8 +: 8]) begin
            eq = 1'b0;
         end
      end
   end

   assign o_match = eq && !order_bad_r && (next_r == (IW+1)'(KEY_BYTES));
endmodule

// >>> fsu_guard_sva.sv
// port-level assertions for the flash protect and security unit
`timescale 1ns/1ps
module fsu_guard_sva
   import fsu_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic o_wb_ack,
   input wire fsu_mem_req_t i_mem_req,
   input wire logic [7:0] i_mem_rdata,
   input wire logic [15:0] o_mem_addr,
   input wire logic o_mem_wr_en,
   input wire logic [7:0] o_mem_rdata,
   input wire logic o_key_capture,
   input wire fsu_cmd_t i_cmd,
   input wire fsu_cmd_res_t o_cmd_res,
   input wire logic o_debug_en_ok,
   input wire logic o_bgnd_mode_ok,
   input wire logic o_secure
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   logic blk;
   logic rd_sec;
   // untrusted request aimed at secure memory while secured
   assign blk = i_mem_req.valid && o_secure && i_mem_req.tgt_secure &&
      (!i_mem_req.src_secure || i_mem_req.from_bdm);
   assign rd_sec = i_mem_req.valid && !i_mem_req.write && i_mem_req.src_secure;
   wb_ack_pulse_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
      else $error("ack is not one pulse one cycle after request");
   cmd_answer_a: assert property (i_cmd.valid |=> $onehot(o_cmd_res))
      else $error("command verdict not one-hot");
   bdm_cmd_err_a: assert property (i_cmd.valid && i_cmd.from_bdm && o_secure &&
      i_cmd.code != FSU_CMD_BLANK && i_cmd.code != FSU_CMD_MASS |=> o_cmd_res.access_err)
      else $error("secured debug command not flagged");
   blocked_write_a: assert property (blk && i_mem_req.write |-> !o_mem_wr_en)
      else $error("blocked write reached memory");
   blocked_read_a: assert property (blk && !i_mem_req.write |=> o_mem_rdata == 8'h00)
      else $error("blocked read returned data");
   secure_read_a: assert property (rd_sec && !i_mem_req.from_bdm |=>
      o_mem_rdata == $past(i_mem_rdata))
      else $error("secure code read lost data");
   reset_vec_a: assert property (i_mem_req.valid && i_mem_req.vec_fetch &&
      i_mem_req.addr[15:1] == 15'h7fff |-> o_mem_addr == i_mem_req.addr)
      else $error("reset vector was redirected");
   vec_low_bits_a: assert property (i_mem_req.valid && i_mem_req.vec_fetch |->
      o_mem_addr[8:0] == i_mem_req.addr[8:0])
      else $error("vector low bits altered");
   key_cap_a: assert property (o_key_capture |-> !o_mem_wr_en)
      else $error("captured key byte also written");
   debug_gate_a: assert property (o_debug_en_ok == !o_secure)
      else $error("debug enable not tied to security");
   bgnd_open_a: assert property (!o_secure |-> o_bgnd_mode_ok)
      else $error("background refused while unsecured");
   cover property (o_cmd_res.prot_reject);
   cover property (o_key_capture);
   cover property ($fell(o_secure));
endmodule
bind fsu_flash_guard fsu_guard_sva u_sva (.i_ref_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .o_wb_ack,
   .i_mem_req, .i_mem_rdata, .o_mem_addr, .o_mem_wr_en, .o_mem_rdata, .o_key_capture, .i_cmd,
   .o_cmd_res, .o_debug_en_ok, .o_bgnd_mode_ok, .o_secure);

// >>> fsu_mem_model.sv
// behavioural memory behind the guard's memory path
`timescale 1ns/1ps
module fsu_mem_model (
   input wire logic i_ref_clk,
   input wire logic [15:0] i_addr,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata
);
   logic [7:0] mem_r [256];
   logic [7:0] last_r;
   initial begin
      last_r = 8'h00;
      for (int i = 0; i < 256; i++)
         mem_r[i] = 8'(i) ^ 8'ha5;
   end
   always @(posedge i_ref_clk) begin
      if (i_wr_en)
         mem_r[i_addr[7:0]] <= i_wdata;
      if (i_rd_en)
         last_r <= o_rdata;
   end
   // idle bus shows the inverse so a stale byte never passes for a read
   assign o_rdata = i_rd_en ? mem_r[i_addr[7:0]] : ~last_r;
endmodule

// >>> tb_top.sv
// self-checking bench for the flash guard
`timescale 1ns/1ps
module tb_top;
   import fsu_pkg::*;
   logic clk = 0;
   logic rst = 1;
   logic cyc = 0;
   logic stb = 0;
   logic we = 0;
   logic bdm = 0;
   logic pin = 1;
   logic [7:0] adr = 0;
   logic [31:0] wdat = 0;
   logic [7:0] nvp = 8'hff;
   logic [7:0] nvo = 8'hff;
   logic [63:0] key = 0;
   logic bdone = 0;
   logic bpass = 0;
   logic bbdm = 0;
   fsu_mem_req_t mreq = '0;
   fsu_cmd_t cmd = '0;
   logic [31:0] wb_q, q;
   logic ack, wren, rden, kcap, dbg_ok, bg_ok, sec, m_wr, m_cap;
   logic [7:0] mrd, mrdat, m_rd, p;
   logic [15:0] maddr, m_addr, a;
   fsu_cmd_res_t res;
   logic [2:0] r;
   logic [6:0] bnd;
   logic [7:0] codes [5] = '{FSU_CMD_BLANK, FSU_CMD_PROG, FSU_CMD_BURST, FSU_CMD_PAGE, FSU_CMD_MASS};
   int fail_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   initial forever #10 clk = ~clk;
   fsu_flash_guard dut (.i_ref_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wdat), .i_wb_bdm(bdm),
      .o_wb_dat(wb_q), .o_wb_ack(ack), .i_nv_prot(nvp), .i_nv_opt(nvo), .i_backdoor_key(key),
      .i_background_mode_pin(pin), .i_mem_req(mreq), .i_mem_rdata(mrd), .o_mem_addr(maddr),
      .o_mem_wr_en(wren), .o_mem_rd_en(rden), .o_mem_rdata(mrdat), .o_key_capture(kcap),
      .i_cmd(cmd), .o_cmd_res(res), .i_blank_done(bdone), .i_blank_pass(bpass),
      .i_blank_bdm(bbdm), .o_debug_en_ok(dbg_ok), .o_bgnd_mode_ok(bg_ok), .o_secure(sec));
   fsu_mem_model u_mem (.i_ref_clk(clk), .i_addr(maddr), .i_wr_en(wren), .i_rd_en(rden),
      .i_wdata(mreq.wdata), .o_rdata(mrd));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // generous ceiling, the whole sequence needs about five hundred cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   function automatic logic prot_hit(input logic [7:0] pv, input logic [15:0] ad);
      return !pv[0] && (ad > {pv[7:1], 9'h1ff} || ad >= FSU_VEC_LO);
   endfunction
   function automatic logic [15:0] redir(input logic [7:0] pv, ov, input logic [15:0] ad);
      if (!pv[0] && !ov[6] && pv[7:1] != 7'h7f && pv[7:1] != 7'h00 && ad <= FSU_VEC_HI &&
         ad >= FSU_VEC_LO)
         return {pv[7:1], ad[8:0]};
      return ad;
   endfunction
   task automatic rst_to(input logic [7:0] pv, ov, input logic pn);
      rst <= 1;
      nvp <= pv;
      nvo <= ov;
      pin <= pn;
      repeat (12) @(posedge clk);
      rst <= 0;
      repeat (3) @(posedge clk);
   endtask
   task automatic wb(input logic w, input logic [7:0] ad, input logic [7:0] d, input logic b);
      int n;
      @(posedge clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= ad;
      wdat <= {24'h0, d};
      bdm <= b;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = wb_q;
      cyc <= 0;
      stb <= 0;
      if (n >= 20)
         chk(0, 1);
   endtask
   task automatic stat_chk(input logic [5:0] mask, input logic [5:0] exp);
      wb(0, FSU_OFS_STAT, 0, 0);
      chk(q[5:0] & mask, exp);
   endtask
   task automatic mem(input logic w, v, ss, b, input logic [15:0] ad, input logic [7:0] d);
      @(posedge clk);
      mreq <= {1'b1, w, v, ss, b, 1'b1, ad, d};
      #1;
      m_addr = maddr;
      m_wr = wren;
      m_cap = kcap;
      chk(rden, !w);
      @(posedge clk);
      mreq.valid <= 0;
      #1 m_rd = mrdat;
   endtask
   task automatic cmd_go(input logic b, input logic [7:0] c, input logic [15:0] ad);
      @(posedge clk);
      cmd <= {1'b1, b, c, ad};
      @(posedge clk);
      cmd.valid <= 0;
      #1 r = res;
   endtask
   // one idle cycle between key bytes keeps them off adjacent bus cycles
   // e: backdoor enabled, so secure firmware writes are captured
   task automatic key_in(input logic b, input logic [63:0] k, input logic e);
      wb(1, FSU_OFS_CFG, 8'h20, 0);
      for (int i = 0; i < 8; i++) begin
         mem(1, 0, 1, b, FSU_KEY_BASE + 16'(i), k[8*i+:8]);
         chk({m_cap, m_wr}, {!b && e, 1'b0});
      end
      wb(1, FSU_OFS_CFG, 8'h00, 0);
      repeat (2) @(posedge clk);
   endtask
   task automatic blank(input logic ps);
      @(posedge clk);
      bdone <= 1;
      bpass <= ps;
      bbdm <= 1;
      @(posedge clk);
      bdone <= 0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   initial begin
      void'($urandom(32'he3d14735));
      key = {$urandom, $urandom};
      rst_to(8'hf8, 8'h3e, 1);
      stat_chk(6'h1f, 6'h1c);
      wb(0, FSU_OFS_PROT, 0, 0);
      chk(q[7:0], 8'hf8);
      wb(0, FSU_OFS_OPT, 0, 0);
      chk(q[7:0], 8'h3e);
      wb(1, FSU_OFS_PROT, 8'h00, 0);
      wb(1, FSU_OFS_OPT, 8'h00, 0);
      wb(0, FSU_OFS_PROT, 0, 0);
      chk(q[7:0], 8'hf8);
      wb(0, FSU_OFS_OPT, 0, 0);
      chk(q[7:0], 8'h3e);
      wb(0, 8'h10, 0, 0);
      chk(q, 0);
      for (int i = 0; i < 12; i++) begin
         bnd = i == 0 ? 7'h7f : i == 1 ? 7'h00 : 7'($urandom_range(1, 126));
         p = {bnd, i == 11};
         wb(1, FSU_OFS_PROT, p, 1);
         a = {bnd, 9'h1ff};
         for (int j = 0; j < 4; j++) begin
            cmd_go(0, FSU_CMD_PROG, a);
            chk(r, prot_hit(p, a) ? 3'b010 : 3'b100);
            a = j == 0 ? a + 16'h1 : j == 1 ? 16'($urandom) : 16'hffc2;
         end
         a = FSU_VEC_LO + 16'($urandom_range(0, 61));
         mem(0, 1, 1, 0, a, 0);
         chk(m_addr, redir(p, 8'h3e, a));
         mem(0, 1, 1, 0, 16'hfffe, 0);
         chk(m_addr, 16'hfffe);
      end
      for (int s = 0; s < 4; s++) begin
         rst_to(8'hff, {6'h3f, 2'(s)}, 1);
         stat_chk(6'h01, {5'h0, s != 2});
         chk({dbg_ok, bg_ok}, {2{s == 2}});
      end
      rst_to(8'hff, 8'hff, 0);
      chk({dbg_ok, bg_ok}, 2'b01);
      rst_to(8'hff, 8'hff, 1);
      mem(0, 0, 0, 0, 16'h1234, 0);
      chk(m_rd, 0);
      mem(0, 0, 1, 1, 16'h1234, 0);
      chk(m_rd, 0);
      mem(1, 0, 0, 0, 16'h2000, 8'h3c);
      chk(m_wr, 0);
      mem(0, 0, 1, 0, 16'h1234, 0);
      chk(m_rd, 8'h34 ^ 8'ha5);
      foreach (codes[k]) begin
         cmd_go(1, codes[k], 16'h1000);
         chk(r, codes[k] inside {FSU_CMD_BLANK, FSU_CMD_MASS} ? 3'b100 : 3'b001);
      end
      wb(1, FSU_OFS_PROT, 8'hf8, 1);
      mem(0, 1, 1, 0, 16'hffe0, 0);
      chk(m_addr, 16'hffe0);
      wb(1, FSU_OFS_PROT, 8'hff, 1);
      key_in(0, key ^ 64'h100, 1);
      stat_chk(6'h23, 6'h21);
      key_in(1, key, 1);
      stat_chk(6'h03, 6'h01);
      key_in(0, key, 1);
      stat_chk(6'h23, 6'h02);
      rst_to(8'hff, 8'hff, 1);
      stat_chk(6'h01, 6'h01);
      rst_to(8'hff, 8'h7f, 1);
      key_in(0, key, 0);
      stat_chk(6'h01, 6'h01);
      rst_to(8'hff, 8'hff, 1);
      blank(0);
      chk(sec, 1);
      blank(1);
      chk(sec, 0);
      tally_and_finish();
   end
endmodule
